//--- tws_pkg.sv
// Purpose: constants for the two-wire control block
// Assumes: registers sit at four times their index on the register port
// Notes: offsets below are register indexes
package tws_pkg;
	// ------------------------------------------------------------
	// register indexes
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CONTROL_A = 6'h00;
	localparam logic [5:0] IDX_CONTROL_B = 6'h04;
	localparam logic [5:0] IDX_BAUD = 6'h0C;
	localparam logic [5:0] IDX_INT_DISABLE = 6'h14;
	localparam logic [5:0] IDX_INT_ARM = 6'h16;
	localparam logic [5:0] IDX_INT_FLAGS = 6'h18;
	localparam logic [5:0] IDX_BUS_STATUS = 6'h1A;
	localparam logic [5:0] IDX_SYNC_PENDING = 6'h1C;
	localparam logic [5:0] IDX_TARGET_ADDR = 6'h24;
	localparam logic [5:0] IDX_HALT_DEBUG = 6'h30;
	// ------------------------------------------------------------
	// writable masks and reset values
	// ------------------------------------------------------------
	localparam logic [31:0] CA_WMASK = 32'h7BF1009C;
	localparam logic [31:0] CB_WMASK = 32'h00070300;
	localparam logic [31:0] AD_WMASK = 32'h00FFE7FF;
	localparam logic [31:0] REG_RST = 32'h00000000;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CA_SOFTWARE_RESET_BIT = 0;
	localparam int CA_ENABLE = 1;
	localparam int CA_MODE_LSB = 2;
	localparam int CA_CLOCK_STRETCH_MODE_SELECT = 27;
	localparam int CB_CMD_LSB = 16;
	localparam int INT_MB = 0;
	localparam int INT_SB = 1;
	localparam int INT_ERROR = 2;
	localparam int INT_ERROR_POS = 7;
	localparam int DATA_LSB = 8;
	localparam int DATA_PUSH = 16;
	localparam int ST_RXNACK = 2;
	localparam int ST_BUS_LSB = 4;
	localparam int ST_CLKHOLD = 7;
	localparam int SP_SOFTWARE_RESET_BIT = 0;
	localparam int SP_ENABLE = 1;
	localparam int AD_OWN_LSB = 1;
	localparam int AD_MASK_LSB = 17;
	localparam int XFER_START = 8;
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_MASTER = 3'h4;
	localparam logic [2:0] MODE_SLAVE = 3'h5;
	localparam logic [1:0] CMD_STOP = 2'h3;
	localparam logic [1:0] BUS_UNKNOWN = 2'h0;
	localparam logic [1:0] BUS_IDLE = 2'h1;
	localparam logic [1:0] BUS_OWNER = 2'h2;
	localparam logic [1:0] BUS_BUSY = 2'h3;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int XFER_W = 9;
	localparam int FIFO_DEPTH = 4;
endpackage : tws_pkg

//--- tws_fifo.sv
// Purpose: small synchronous buffer with valid and ready on both sides
// Assumes: one clock, depth a power of two
// Notes: clr empties the buffer in one cycle
`timescale 1ns/1ps
module tws_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic clr,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("tws_fifo: DEPTH must be a power of two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem_q[rd_q[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (clr) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule : tws_fifo

//--- tws_ctrl.sv
// Purpose: two-wire bus controller, master or slave, register side
// Assumes: link pins and line logic run on core_clk, registers on ref_clk
// Notes: master sends bytes only; slave reports address match, no ack
`timescale 1ns/1ps
module tws_ctrl
	import tws_pkg::*;
(
	// register side
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link side
	input wire logic core_clk,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	function automatic logic [31:0] wmerge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] mask);
		wmerge = (old_v & ~mask) | (new_v & mask);
	endfunction : wmerge

	// ------------------------------------------------------------
	// register side state
	// ------------------------------------------------------------
	logic [31:0] ctrl_a_q;
	logic enable_q;
	logic software_reset_bit_t_q;
	logic [31:0] ctrl_b_q;
	logic [31:0] baud_q;
	logic [31:0] addr_q;
	logic [2:0] inten_q;
	logic [2:0] flag_q;
	logic [7:0] data_q;
	logic dbg_q;
	logic [XFER_W-1:0] xfer_q;
	logic xreq_t_q;
	logic [1:0] bus_st_q;
	// crossings into ref_clk
	logic [1:0] en_ech_s;
	logic [1:0] sw_ack_s;
	logic [1:0] xack_s;
	logic [2:0] bit8_s;
	logic [2:0] ack_s;
	logic [2:0] match_s;
	logic [1:0] nack_s;
	logic [1:0] hold_s;
	logic [1:0] bus_a_s;
	logic [1:0] bus_b_s;
	logic [1:0] bus_c_q;

	logic [5:0] idx;
	logic wr;
	logic busy_en;
	logic busy_sw;
	logic software_reset_bit_wr;
	logic reject;
	logic push;
	logic accept;
	logic f_ready;
	logic f_valid;
	logic f_pop;
	logic [XFER_W-1:0] f_data;
	logic [XFER_W-1:0] push_word;
	logic ev_bit8;
	logic ev_ack;
	logic ev_match;
	logic [2:0] set_v;
	logic [2:0] clr_v;
	logic [31:0] rd_v;

	assign idx = paddr[7:2];
	assign wr = psel & penable & pwrite;
	assign busy_en = enable_q != en_ech_s[1];
	assign busy_sw = software_reset_bit_t_q != sw_ack_s[1];
	assign software_reset_bit_wr = wr & (idx == IDX_CONTROL_A) & pwdata[CA_SOFTWARE_RESET_BIT];
	assign reject = wr & (busy_sw | (busy_en & ~software_reset_bit_wr));
	assign push = wr & ~reject & (ctrl_a_q[CA_MODE_LSB+:3] == MODE_MASTER)
		& ((idx == IDX_TARGET_ADDR)
		| ((idx == IDX_INT_FLAGS) & pwdata[DATA_PUSH]));
	assign push_word = (idx == IDX_TARGET_ADDR)
		? {1'b1, pwdata[7:0]} : {1'b0, pwdata[DATA_LSB+:8]};
	// a full buffer stalls the bus so no byte is dropped
	assign pready = ~(push & ~f_ready);
	assign pslverr = reject;
	assign accept = wr & pready & ~reject;
	assign f_pop = f_valid & (xreq_t_q == xack_s[1]);
	assign ev_bit8 = bit8_s[2] ^ bit8_s[1];
	assign ev_ack = ack_s[2] ^ ack_s[1];
	assign ev_match = match_s[2] ^ match_s[1];

	tws_fifo #(
		.WIDTH(XFER_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.rstn(rstn),
		.clr(software_reset_bit_wr & ~busy_sw),
		.in_valid(push),
		.in_ready(f_ready),
		.in_data(push_word),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_a_q <= REG_RST;
			enable_q <= 1'b0;
			software_reset_bit_t_q <= 1'b0;
			ctrl_b_q <= REG_RST;
			baud_q <= REG_RST;
			addr_q <= REG_RST;
			data_q <= '0;
		end else if (software_reset_bit_wr & ~busy_sw) begin
			ctrl_a_q <= REG_RST;
			enable_q <= 1'b0;
			software_reset_bit_t_q <= ~software_reset_bit_t_q;
			ctrl_b_q <= REG_RST;
			baud_q <= REG_RST;
			addr_q <= REG_RST;
			data_q <= '0;
		end else begin
			if (accept & (idx == IDX_CONTROL_A)) begin
				enable_q <= pwdata[CA_ENABLE];
				// mode fields are locked while running
				if (!enable_q)
					ctrl_a_q <= wmerge(ctrl_a_q, pwdata, CA_WMASK);
			end
			if (accept & (idx == IDX_CONTROL_B))
				ctrl_b_q <= wmerge(ctrl_b_q, pwdata, CB_WMASK);
			else if (bus_c_q == BUS_IDLE && bus_st_q != BUS_IDLE)
				ctrl_b_q[CB_CMD_LSB+:2] <= 2'h0;
			if (accept & (idx == IDX_BAUD) & ~enable_q)
				baud_q <= pwdata;
			if (accept & (idx == IDX_TARGET_ADDR) & ~enable_q)
				addr_q <= wmerge(addr_q, pwdata, AD_WMASK);
			if (accept & push)
				data_q <= push_word[7:0];
		end
	end

	// debug register survives software reset
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			dbg_q <= 1'b0;
		else if (accept & (idx == IDX_HALT_DEBUG))
			dbg_q <= pwdata[0];
	end

	// ------------------------------------------------------------
	// interrupt enables and flags
	// ------------------------------------------------------------
	assign clr_v = (accept & (idx == IDX_INT_FLAGS))
		? {pwdata[INT_ERROR_POS], pwdata[INT_SB], pwdata[INT_MB]} : 3'h0;
	assign set_v = {ev_ack & nack_s[1], ev_match & ~busy_sw,
		ctrl_a_q[CA_CLOCK_STRETCH_MODE_SELECT] ? ev_ack : ev_bit8};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			inten_q <= '0;
			flag_q <= '0;
		end else if (software_reset_bit_wr & ~busy_sw) begin
			inten_q <= '0;
			flag_q <= '0;
		end else begin
			if (accept & (idx == IDX_INT_ARM))
				inten_q <= inten_q | {pwdata[INT_ERROR_POS], pwdata[1:0]};
			if (accept & (idx == IDX_INT_DISABLE))
				inten_q <= inten_q & ~{pwdata[INT_ERROR_POS], pwdata[1:0]};
			// a new event wins over a clear in the same cycle
			flag_q <= (flag_q & ~clr_v) | set_v;
		end
	end

	// ------------------------------------------------------------
	// byte handoff to the link
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			xfer_q <= '0;
			xreq_t_q <= 1'b0;
		end else if (f_pop) begin
			xfer_q <= f_data;
			xreq_t_q <= ~xreq_t_q;
		end
	end

	// ------------------------------------------------------------
	// crossings from the link
	// ------------------------------------------------------------
	logic en_l_q;
	logic sw_ack_q;
	logic xtaken_q;
	logic bit8_t_q;
	logic ack_t_q;
	logic match_t_q;
	logic nack_q;
	logic hold_q;
	logic [1:0] bus_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			en_ech_s <= '0;
			sw_ack_s <= '0;
			xack_s <= '0;
			bit8_s <= '0;
			ack_s <= '0;
			match_s <= '0;
			nack_s <= '0;
			hold_s <= '0;
			bus_a_s <= '0;
			bus_b_s <= '0;
			bus_c_q <= '0;
			bus_st_q <= BUS_UNKNOWN;
		end else begin
			en_ech_s <= {en_ech_s[0], en_l_q};
			sw_ack_s <= {sw_ack_s[0], sw_ack_q};
			xack_s <= {xack_s[0], xtaken_q};
			bit8_s <= {bit8_s[1:0], bit8_t_q};
			ack_s <= {ack_s[1:0], ack_t_q};
			match_s <= {match_s[1:0], match_t_q};
			nack_s <= {nack_s[0], nack_q};
			hold_s <= {hold_s[0], hold_q};
			bus_a_s <= {bus_a_s[0], bus_q[0]};
			bus_b_s <= {bus_b_s[0], bus_q[1]};
			bus_c_q <= {bus_b_s[1], bus_a_s[1]};
			// two-bit state taken only when two samples agree
			if (bus_c_q == {bus_b_s[1], bus_a_s[1]})
				bus_st_q <= bus_c_q;
		end
	end

	// ------------------------------------------------------------
	// register read
	// ------------------------------------------------------------
	always_comb begin
		rd_v = '0;
		case (idx)
			IDX_CONTROL_A: rd_v = ctrl_a_q | {30'h0, enable_q, 1'b0};
			IDX_CONTROL_B: rd_v = ctrl_b_q;
			IDX_BAUD: rd_v = baud_q;
			IDX_INT_DISABLE, IDX_INT_ARM:
				rd_v = {24'h0, inten_q[2], 5'h0, inten_q[1:0]};
			IDX_INT_FLAGS: rd_v = {16'h0, data_q, flag_q[2], 5'h0, flag_q[1:0]};
			IDX_BUS_STATUS: begin
				rd_v[ST_CLKHOLD] = hold_s[1];
				rd_v[ST_BUS_LSB+:2] = bus_st_q;
				rd_v[ST_RXNACK] = nack_s[1];
			end
			IDX_SYNC_PENDING: begin
				rd_v[SP_SOFTWARE_RESET_BIT] = busy_sw;
				rd_v[SP_ENABLE] = busy_en;
			end
			IDX_TARGET_ADDR: rd_v = addr_q;
			IDX_HALT_DEBUG: rd_v = {31'h0, dbg_q};
			default: rd_v = '0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			prdata <= '0;
		else if (psel & ~penable & ~pwrite)
			prdata <= rd_v;
	end

	// ------------------------------------------------------------
	// link side: pin and control synchronisers
	// ------------------------------------------------------------
	typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_HOLD, M_STOP} tws_mst_e;
	tws_mst_e st_q;
	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic scl_p_q;
	logic sda_p_q;
	logic [1:0] en_s;
	logic [1:0] sw_s;
	logic [1:0] xreq_s;
	logic [1:0] stop_s;
	logic [2:0] mode_l_q;
	logic [7:0] baud_l_q;
	logic [14:0] own_l_q;
	logic [7:0] div_q;
	logic ph_q;
	logic [2:0] cnt_q;
	logic [7:0] sh_q;
	logic [2:0] mon_cnt_q;
	logic [7:0] mon_sh_q;
	logic sda_lo_q;
	logic scl_lo_q;
	logic tick;
	logic sw_hit;
	logic new_word;
	logic start_det;
	logic stop_det;
	logic scl_rise;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			en_s <= '0;
			sw_s <= '0;
			xreq_s <= '0;
			stop_s <= '0;
		end else begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			en_s <= {en_s[0], enable_q};
			sw_s <= {sw_s[0], software_reset_bit_t_q};
			xreq_s <= {xreq_s[0], xreq_t_q};
			stop_s <= {stop_s[0], ctrl_b_q[CB_CMD_LSB+:2] == CMD_STOP};
		end
	end

	assign sw_hit = sw_s[1] != sw_ack_q;
	assign tick = div_q == baud_l_q;
	assign new_word = xreq_s[1] != xtaken_q;
	assign start_det = scl_s[1] & scl_p_q & sda_p_q & ~sda_s[1];
	assign stop_det = scl_s[1] & scl_p_q & ~sda_p_q & sda_s[1];
	assign scl_rise = scl_s[1] & ~scl_p_q;

	// ------------------------------------------------------------
	// link side: enable, reset and configuration capture
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_l_q <= 1'b0;
			sw_ack_q <= 1'b0;
			mode_l_q <= '0;
			baud_l_q <= '0;
			own_l_q <= '0;
		end else begin
			en_l_q <= en_s[1] & ~sw_hit;
			sw_ack_q <= sw_s[1];
			// settings are frozen while enabled, so taking them here is safe
			if (en_s[1] & ~en_l_q) begin
				mode_l_q <= ctrl_a_q[CA_MODE_LSB+:3];
				baud_l_q <= baud_q[7:0];
				own_l_q <= {addr_q[AD_MASK_LSB+:7],
					addr_q[AD_OWN_LSB+:7], 1'b0};
			end
		end
	end

	// ------------------------------------------------------------
	// link side: master byte engine
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= M_IDLE;
			div_q <= '0;
			ph_q <= 1'b0;
			cnt_q <= '0;
			sh_q <= '0;
			xtaken_q <= 1'b0;
			bit8_t_q <= 1'b0;
			ack_t_q <= 1'b0;
			nack_q <= 1'b0;
		end else if (sw_hit || !en_l_q || mode_l_q != MODE_MASTER) begin
			st_q <= M_IDLE;
			div_q <= '0;
			ph_q <= 1'b0;
			xtaken_q <= xreq_s[1];
		end else begin
			div_q <= tick ? 8'h00 : div_q + 8'h01;
			case (st_q)
				M_IDLE: if (new_word) begin
					sh_q <= xfer_q[7:0];
					xtaken_q <= xreq_s[1];
					// restart the divider so the start hold is a full half bit
					div_q <= 8'h00;
					st_q <= M_START;
				end
				M_START: if (tick) begin
					ph_q <= 1'b0;
					cnt_q <= '0;
					st_q <= M_BIT;
				end
				M_BIT: if (tick) begin
					ph_q <= ~ph_q;
					if (ph_q) begin
						sh_q <= {sh_q[6:0], 1'b0};
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == LAST_BIT) begin
							bit8_t_q <= ~bit8_t_q;
							st_q <= M_ACK;
						end
					end
				end
				M_ACK: if (tick) begin
					ph_q <= ~ph_q;
					if (ph_q) begin
						nack_q <= sda_s[1];
						ack_t_q <= ~ack_t_q;
						st_q <= M_HOLD;
					end
				end
				// clock held low until software gives more work
				M_HOLD: if (new_word) begin
					sh_q <= xfer_q[7:0];
					xtaken_q <= xreq_s[1];
					cnt_q <= '0;
					div_q <= 8'h00;
					st_q <= M_BIT;
				end else if (stop_s[1]) begin
					ph_q <= 1'b0;
					st_q <= M_STOP;
				end
				M_STOP: if (tick) begin
					ph_q <= ~ph_q;
					if (ph_q)
						st_q <= M_IDLE;
				end
				default: st_q <= M_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// link side: bus monitor, always running on core_clk
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			mon_cnt_q <= '0;
			mon_sh_q <= '0;
			match_t_q <= 1'b0;
			bus_q <= BUS_UNKNOWN;
		end else begin
			scl_p_q <= scl_s[1];
			sda_p_q <= sda_s[1];
			if (start_det) begin
				mon_cnt_q <= '0;
			end else if (scl_rise) begin
				mon_cnt_q <= mon_cnt_q + 3'h1;
				mon_sh_q <= {mon_sh_q[6:0], sda_s[1]};
				if (mon_cnt_q == LAST_BIT && mode_l_q == MODE_SLAVE
					&& bus_q == BUS_BUSY && en_l_q
					&& ((({mon_sh_q[6:0], sda_s[1]} ^ own_l_q[7:0])
					& ~{own_l_q[14:8], 1'b0}) & 8'hFE) == 8'h00)
					match_t_q <= ~match_t_q;
			end
			if (!en_l_q)
				bus_q <= BUS_UNKNOWN;
			else if (bus_q == BUS_UNKNOWN || stop_det)
				bus_q <= BUS_IDLE;
			else if (start_det)
				bus_q <= (st_q == M_START) ? BUS_OWNER : BUS_BUSY;
		end
	end

	// ------------------------------------------------------------
	// link side: open-drain drivers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sda_lo_q <= 1'b0;
			scl_lo_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			// data moves only once the clock is already low; the stop
			// edge follows a half bit after the clock is released
			sda_lo_q <= (st_q == M_START) | (st_q == M_STOP)
				| (st_q == M_HOLD & stop_s[1])
				| ((st_q == M_BIT | st_q == M_ACK) & sda_lo_q
				& ~(scl_lo_q & ~ph_q))
				| (st_q == M_BIT & scl_lo_q & ~ph_q & ~sh_q[7]);
			scl_lo_q <= ((st_q == M_BIT | st_q == M_ACK) & ~ph_q)
				| (st_q == M_HOLD) | (st_q == M_STOP & ~ph_q);
			hold_q <= st_q == M_HOLD;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_lo_q;
	assign sda_oe = sda_lo_q;
endmodule : tws_ctrl

//--- tws_monitor.sv
// Purpose: register-side checks for the two-wire control block
// Assumes: crossings finish well inside 100 register clocks
// Notes: helper counters track accepted writes seen at the ports
`timescale 1ns/1ps
module tws_monitor
	import tws_pkg::*;
(
	// register side
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ------
	// helpers
	// ------
	logic acc_w, acc_r, ok_w, ca_w, rst_w, sp_r;
	logic [7:0] c_rst_q, c_en_q;
	logic en_q, tog_q, clean_q, dbg_q;
	assign acc_w = psel && penable && pwrite && pready;
	assign acc_r = psel && penable && !pwrite && pready;
	assign ok_w = acc_w && !pslverr;
	assign ca_w = ok_w && paddr[7:2] == IDX_CONTROL_A;
	assign rst_w = ca_w && pwdata[CA_SOFTWARE_RESET_BIT];
	assign sp_r = acc_r && paddr[7:2] == IDX_SYNC_PENDING;
	// saturating, so a stale count never wraps into a busy window
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) c_rst_q <= 8'hFF;
		else if (rst_w) c_rst_q <= 8'h00;
		else if (c_rst_q != 8'hFF) c_rst_q <= c_rst_q + 8'h01;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) c_en_q <= 8'hFF;
		else if (ca_w) c_en_q <= 8'h00;
		else if (c_en_q != 8'hFF) c_en_q <= c_en_q + 8'h01;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			en_q <= 1'h0;
			tog_q <= 1'h0;
		end else if (ca_w) begin
			en_q <= pwdata[CA_ENABLE] && !pwdata[CA_SOFTWARE_RESET_BIT];
			tog_q <= !pwdata[CA_SOFTWARE_RESET_BIT] && pwdata[CA_ENABLE] != en_q;
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) clean_q <= 1'h1;
		else if (rst_w) clean_q <= 1'h1;
		else if (ok_w) clean_q <= 1'h0;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) dbg_q <= 1'h0;
		else if (ok_w && paddr[7:2] == IDX_HALT_DEBUG) dbg_q <= pwdata[0];
	end
	// ------
	// checks
	// ------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_reset_refuse:
		assert property (acc_w && c_rst_q < 8'h08 |-> pslverr)
		else $error("write taken during reset crossing");
	a_enable_refuse:
		assert property (acc_w && c_en_q < 8'h08 && tog_q
			&& !(paddr[7:2] == IDX_CONTROL_A && pwdata[CA_SOFTWARE_RESET_BIT]) |-> pslverr)
		else $error("write taken during enable crossing");
	a_reset_taken:
		assert property (acc_w && paddr[7:2] == IDX_CONTROL_A
			&& pwdata[CA_SOFTWARE_RESET_BIT] && c_rst_q > 8'h64 |-> !pslverr)
		else $error("reset write refused");
	a_enable_busy:
		assert property (sp_r && c_en_q < 8'h08 && tog_q |-> prdata[SP_ENABLE])
		else $error("enable busy flag not set");
	a_reset_busy:
		assert property (sp_r && c_rst_q < 8'h08 |-> prdata[SP_SOFTWARE_RESET_BIT])
		else $error("reset busy flag not set");
	a_busy_clears:
		assert property (sp_r && c_rst_q > 8'h64 && c_en_q > 8'h64
			|-> prdata[1:0] == 2'h0)
		else $error("busy flag stuck");
	a_reset_clears:
		assert property (acc_r && clean_q && (paddr[7:2] == IDX_CONTROL_A
			|| paddr[7:2] == IDX_BAUD || paddr[7:2] == IDX_TARGET_ADDR)
			|-> prdata == REG_RST)
		else $error("register not cleared by reset");
	a_debug_kept:
		assert property (acc_r && paddr[7:2] == IDX_HALT_DEBUG
			|-> prdata[0] == dbg_q)
		else $error("debug register lost its value");
endmodule : tws_monitor

//--- tws_partner.sv
// Purpose: remote slave node on the two-wire bus
// Assumes: both lines pulled up, pull high drives the line low
// Notes: acks on request, no clock stretching
`timescale 1ns/1ps
module tws_partner (
	// bus lines
	input wire logic scl,
	input wire logic sda,
	// control and capture
	input wire logic ack_en,
	output logic pull,
	output logic [7:0] rx,
	output logic [3:0] cnt,
	output int nrx
);
	logic act = 1'h0;
	logic [7:0] sh = 8'h00;
	initial begin
		pull = 1'h0;
		cnt = 4'h0;
		nrx = 0;
		rx = 8'h00;
	end
	always @(negedge sda) if (scl) begin
		act = 1'h1;
		cnt = 4'h0;
	end
	always @(posedge sda) if (scl) act = 1'h0;
	// msb arrives first
	always @(posedge scl) if (act && cnt < 4'h8) begin
		sh = {sh[6:0], sda};
		cnt++;
		if (cnt == 4'h8) begin
			rx = sh;
			nrx++;
		end
	end
	always @(negedge scl) if (act) begin
		if (cnt == 4'h8) begin
			pull = ack_en;
			cnt = 4'h9;
		end else if (cnt == 4'h9) begin
			pull = 1'h0;
			cnt = 4'h0;
		end
	end
endmodule : tws_partner

//--- tws_ctrl_bench.sv
// Purpose: self-checking bench for the two-wire control block
// Assumes: remote slave acks only in the second pass
// Notes: buffer filled until the bus stalls while the link sends
`timescale 1ns/1ps
module tws_ctrl_bench
	import tws_pkg::*;
;
	// ------
	// wiring
	// ------
	logic ref_clk = 1'h0, core_clk = 1'h0, rstn = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ack_en = 1'h0;
	logic stall = 1'h0, er, pready, pslverr, scl_oe, sda_oe, p_pull;
	logic [7:0] paddr = 8'h00, p_rx;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] p_cnt;
	logic [7:0] q[$], e[$];
	logic [5:0] zl[4] = '{IDX_CONTROL_A, IDX_CONTROL_B, IDX_BAUD,
		IDX_TARGET_ADDR};
	int p_nrx, n_errors = 0, n_checks = 0, cyc = 0, seed = 32'h9D14;
	wire scl_w = !scl_oe;
	wire sda_w = !(sda_oe || p_pull);
	tws_ctrl tws_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_clk(core_clk), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
	tws_partner tws_partner_inst (.scl(scl_w), .sda(sda_w),
		.ack_en(ack_en), .pull(p_pull), .rx(p_rx), .cnt(p_cnt), .nrx(p_nrx));
	initial forever #4 ref_clk = !ref_clk;
	initial begin
		#3;
		forever #32 core_clk = !core_clk;
	end
	// let the captured byte settle before taking it
	always @(p_nrx) #1 q.push_back(p_rx);
	// whole run stays under about 25k cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			print_verdict();
		end
	end
	// ------
	// tasks
	// ------
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [5:0] i,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		@(negedge ref_clk);
		while (pready !== 1'h1 && n < 9000) begin
			n++;
			stall = 1'h1;
			@(negedge ref_clk);
		end
		r = prdata;
		er = pslverr;
		@(posedge ref_clk);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic poll(input logic [5:0] i, input logic [31:0] m,
		input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'h0, i, 32'h0);
			n++;
		end while ((r & m) !== v && n < 4000);
		cmp(r & m, v);
	endtask : poll
	function automatic logic [31:0] ca_word(input logic [2:0] md,
		input logic sm, input logic en);
		return (32'(md) << CA_MODE_LSB) | (32'(sm) << CA_CLOCK_STRETCH_MODE_SELECT)
			| (32'(en) << CA_ENABLE);
	endfunction : ca_word
	// ------
	// sequence
	// ------
	initial begin
		logic [7:0] b;
		logic [31:0] bd;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'h1;
		for (int m = 0; m < 2; m++) begin
			ack_en <= m[0];
			apb(1'h1, IDX_HALT_DEBUG, 32'(m));
			apb(1'h1, IDX_CONTROL_A, 32'h1);
			apb(1'h1, IDX_BAUD, 32'h5);
			cmp(32'(er), 32'h1);
			poll(IDX_SYNC_PENDING, 32'h3, 32'h0);
			foreach (zl[k]) begin
				apb(1'h0, zl[k], 32'h0);
				cmp(r, REG_RST);
			end
			apb(1'h0, IDX_HALT_DEBUG, 32'h0);
			cmp(r & 32'h1, 32'(m));
			// short half bit keeps the run brief
			bd = 32'h8 + 32'($random(seed) & 7);
			apb(1'h1, IDX_CONTROL_A, ca_word(MODE_MASTER, m[0], 1'h0));
			apb(1'h1, IDX_BAUD, bd);
			apb(1'h1, IDX_CONTROL_A, ca_word(MODE_MASTER, m[0], 1'h1));
			apb(1'h1, IDX_BAUD, bd);
			cmp(32'(er), 32'h1);
			apb(1'h0, IDX_SYNC_PENDING, 32'h0);
			cmp(r & 32'h2, 32'h2);
			poll(IDX_SYNC_PENDING, 32'h3, 32'h0);
			apb(1'h0, IDX_CONTROL_A, 32'h0);
			cmp(r, ca_word(MODE_MASTER, m[0], 1'h1));
			poll(IDX_BUS_STATUS, 32'h30, 32'(BUS_IDLE) << ST_BUS_LSB);
			b = 8'($random(seed));
			e.push_back(b);
			apb(1'h1, IDX_TARGET_ADDR, 32'(b));
			poll(IDX_INT_FLAGS, 32'h1, 32'h1);
			// flag runs ahead of the line by up to one link clock
			repeat (16) @(posedge ref_clk);
			cmp(32'(p_cnt >= 4'h8), 32'(m == 0));
			cmp(32'(scl_w), 32'h0);
			if (m == 0) begin
				poll(IDX_INT_FLAGS, 32'h80, 32'h80);
				poll(IDX_BUS_STATUS, 32'h4, 32'h4);
			end else begin
				poll(IDX_BUS_STATUS, 32'hB0, 32'hA0);
				for (int k = 0; k < 6; k++) begin
					b = 8'($random(seed));
					e.push_back(b);
					apb(1'h1, IDX_INT_FLAGS, (32'h1 << DATA_PUSH)
						| (32'(b) << DATA_LSB));
				end
				cmp(32'(stall), 32'h1);
				for (int k = 0; k < 30000 && q.size() < 7; k++)
					@(posedge ref_clk);
				apb(1'h1, IDX_CONTROL_B, 32'(CMD_STOP) << CB_CMD_LSB);
				poll(IDX_BUS_STATUS, 32'h30, 32'(BUS_IDLE) << ST_BUS_LSB);
			end
			apb(1'h1, IDX_INT_FLAGS, 32'h83);
			apb(1'h0, IDX_INT_FLAGS, 32'h0);
			cmp(r & 32'h83, 32'h0);
			apb(1'h0, IDX_SYNC_PENDING, 32'h0);
			cmp(r & 32'h3, 32'h0);
			cmp(32'(q.size()), 32'(e.size()));
			while (q.size() > 0 && e.size() > 0)
				cmp(32'(q.pop_front()), 32'(e.pop_front()));
		end
		// slave setup: stop, mode, then own address and mask
		apb(1'h1, IDX_CONTROL_A, 32'h0);
		poll(IDX_SYNC_PENDING, 32'h3, 32'h0);
		bd = 32'($random(seed)) & AD_WMASK;
		apb(1'h1, IDX_CONTROL_A, ca_word(MODE_SLAVE, 1'h0, 1'h0));
		apb(1'h1, IDX_TARGET_ADDR, bd);
		apb(1'h1, IDX_CONTROL_A, ca_word(MODE_SLAVE, 1'h0, 1'h1));
		poll(IDX_SYNC_PENDING, 32'h3, 32'h0);
		apb(1'h0, IDX_TARGET_ADDR, 32'h0);
		cmp(r, bd);
		apb(1'h0, IDX_CONTROL_A, 32'h0);
		cmp(r, ca_word(MODE_SLAVE, 1'h0, 1'h1));
		poll(IDX_BUS_STATUS, 32'h30, 32'(BUS_IDLE) << ST_BUS_LSB);
		print_verdict();
	end
endmodule : tws_ctrl_bench
bind tws_ctrl tws_monitor tws_monitor_inst (.ref_clk(ref_clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
